// file: pot_bus_host.sv
// 2-wire bus master that frames commands for a four-channel digital pot
// assumes open-drain pins with external pull-ups; one request at a time
//
// Notes on behaviour
// - after start send four-bit type id then four address bits, msb first.
// - slave acks address, instruction, written bytes; master acks read bytes.
// - counter read: zero store bits, slave returns byte, master acks, stop.
// - counter write: zero store bits, master sends byte, slave acks, stop.
// - store read selects store and channel; byte returned, master ack, stop.
// - store write uses opcode 1100 plus data byte; stop starts write cycle.
// - store-to-counter transfer stops after instruction ack; no write cycle.
// - counter-to-store transfer stops after instruction ack; starts write cycle.
// - in step mode each clock high with data high is one increment.
// - in step mode each clock high with data low is one decrement.
// - master sends zero in unused instruction bits; device ignores them.
// - no address ack during a write; master polls start plus address.
`include "pot_host_map.svh"

module pot_bus_host #(
  parameter int         QUARTER_CYCLES = `POT_BUS_BIT_NS / (4 * `POT_CLK_NS),
  parameter int         POLL_LIMIT     = `POT_NV_WRITE_US * 1000 / `POT_CLK_NS,
  parameter logic [3:0] TYPE_ID        = `POT_TYPE_ID_DEFAULT
) (
  input  wire logic               i_clk,
  input  wire logic               i_resetn,
  input  wire logic               i_req_valid,
  input  wire pot_host_pkg::req_t i_req,
  output logic                    o_req_ready,
  output logic                    o_done,
  output pot_host_pkg::rsp_t      o_rsp,
  input  wire logic               i_scl,
  output logic                    o_scl,
  output logic                    o_scl_oe_n,
  input  wire logic               i_sda,
  output logic                    o_sda,
  output logic                    o_sda_oe_n
);
  import pot_host_pkg::*;

  localparam int TW = $clog2(POLL_LIMIT + 1);

  typedef struct packed {
    host_state_t st;
    logic [1:0]  q;
    logic [3:0]  bitn;
    logic [1:0]  byte_idx;
    logic [7:0]  shreg;
    req_t        req;
    logic        polling;
    logic        poll_ok;
    logic [7:0]  steps;
    logic [TW-1:0] timer;
    rsp_t        rsp;
    logic        done;
    logic        ready;
    logic        scl_oe_n;
    logic        sda_oe_n;
    logic        pin_level;
  } host_reg_t;

  host_reg_t s;
  host_reg_t next_s;

  logic tick;
  logic scl_in;
  logic sda_in;

  link_tick_sync #(
    .QUARTER_CYCLES(QUARTER_CYCLES)
  ) u_tick (
    .i_clk   (i_clk),
    .i_resetn(i_resetn),
    .i_scl   (i_scl),
    .i_sda   (i_sda),
    .o_tick  (tick),
    .o_scl   (scl_in),
    .o_sda   (sda_in)
  );

  function automatic logic [3:0] opcode(input cmd_t c);
    case (c)
      CMD_READ_COUNTER:      opcode = `POT_OP_READ_COUNTER;
      CMD_WRITE_COUNTER:     opcode = `POT_OP_WRITE_COUNTER;
      CMD_READ_STORE:        opcode = `POT_OP_READ_STORE;
      CMD_WRITE_STORE:       opcode = `POT_OP_WRITE_STORE;
      CMD_STORE_TO_COUNTER:  opcode = `POT_OP_STORE_TO_CNT;
      CMD_COUNTER_TO_STORE:  opcode = `POT_OP_CNT_TO_STORE;
      CMD_GLOBAL_TO_COUNTER: opcode = `POT_OP_GLOBAL_TO_CNT;
      CMD_GLOBAL_TO_STORE:   opcode = `POT_OP_GLOBAL_TO_ST;
      default:               opcode = `POT_OP_STEP;
    endcase
  endfunction

  // unused fields go out as zero so the device sees defined bits
  function automatic logic [7:0] instr_byte(input req_t r);
    logic [1:0] rs;
    logic [1:0] ps;
    rs = r.store_select;
    ps = r.channel_select;
    if (r.cmd == CMD_READ_COUNTER || r.cmd == CMD_WRITE_COUNTER || r.cmd == CMD_STEP) begin
      rs = 2'h0;
    end
    if (r.cmd == CMD_GLOBAL_TO_COUNTER || r.cmd == CMD_GLOBAL_TO_STORE) begin
      ps = 2'h0;
    end
    instr_byte = {opcode(r.cmd), rs, ps};
  endfunction

  function automatic logic starts_nv_write(input cmd_t c);
    starts_nv_write = (c == CMD_WRITE_STORE) || (c == CMD_COUNTER_TO_STORE) ||
                      (c == CMD_GLOBAL_TO_STORE);
  endfunction

  always_comb begin
    next_s = s;
    next_s.done = 1'b0;
    // the poll timer stops at its ceiling, so a device that never answers ends in a timeout
    if (s.polling && s.timer != TW'(POLL_LIMIT)) begin
      next_s.timer = s.timer + TW'(1);
    end
    case (s.st)
      ST_IDLE: begin
        if (i_req_valid && s.ready) begin
          next_s.req = i_req;
          next_s.ready = 1'b0;
          next_s.polling = 1'b0;
          next_s.poll_ok = 1'b0;
          next_s.timer = '0;
          next_s.rsp = '0;
          next_s.q = 2'h0;
          next_s.st = ST_START;
        end
      end
      ST_START: begin
        if (tick) begin
          next_s.q = s.q + 2'h1;
          case (s.q)
            2'h0: begin
              next_s.sda_oe_n = 1'b1;
              next_s.scl_oe_n = 1'b1;
            end
            2'h1: next_s.sda_oe_n = 1'b0;
            2'h2: next_s.sda_oe_n = 1'b0;
            default: begin
              // the address is reloaded here, so every poll resends the same byte
              next_s.scl_oe_n = 1'b0;
              next_s.st = ST_SEND;
              next_s.bitn = 4'h0;
              next_s.byte_idx = `POT_BYTE_ADDR;
              next_s.shreg = {TYPE_ID, s.req.chip_select_bits};
            end
          endcase
        end
      end
      ST_SEND, ST_RECV, ST_STEP: begin
        if (tick) begin
          next_s.q = s.q + 2'h1;
          case (s.q)
            2'h0: begin
              if (s.st == ST_STEP) begin
                next_s.sda_oe_n = s.req.step_up;
              end else if (s.bitn == `POT_ACK_SLOT) begin
                next_s.sda_oe_n = (s.st == ST_SEND);
              end else begin
                next_s.sda_oe_n = (s.st == ST_SEND) ? s.shreg[7] : 1'b1;
              end
            end
            2'h1: next_s.scl_oe_n = 1'b1;
            2'h2: next_s.scl_oe_n = 1'b1;
            default: begin
              // the slave may hold the clock low; wait for it to rise
              if (!scl_in) begin
                next_s.q = s.q;
              end else begin
                next_s.scl_oe_n = 1'b0;
                next_s.bitn = s.bitn + 4'h1;
                if (s.st == ST_STEP) begin
                  // each step is a bare clock pulse; sda was set while scl was low
                  next_s.steps = s.steps - 8'h01;
                  if (s.steps == 8'h01) begin
                    next_s.st = ST_STOP;
                  end
                end else if (s.bitn != `POT_ACK_SLOT) begin
                  if (s.st == ST_SEND) begin
                    next_s.shreg = {s.shreg[6:0], 1'b0};
                  end else begin
                    next_s.shreg = {s.shreg[6:0], sda_in};
                  end
                end else if (s.st == ST_RECV) begin
                  next_s.rsp.data = s.shreg;
                  next_s.st = ST_STOP;
                end else if (sda_in) begin
                  // no acknowledge: end the frame
                  next_s.rsp.nack = !s.polling;
                  next_s.poll_ok = 1'b0;
                  next_s.st = ST_STOP;
                end else begin
                  next_s.bitn = 4'h0;
                  next_s.byte_idx = s.byte_idx + 2'h1;
                  if (s.polling) begin
                    next_s.poll_ok = 1'b1;
                    next_s.st = ST_STOP;
                  end else if (s.byte_idx == `POT_BYTE_ADDR) begin
                    next_s.shreg = instr_byte(s.req);
                  end else if (s.byte_idx == `POT_BYTE_INSTR) begin
                    case (s.req.cmd)
                      CMD_READ_COUNTER, CMD_READ_STORE: next_s.st = ST_RECV;
                      CMD_WRITE_COUNTER, CMD_WRITE_STORE: begin
                        next_s.shreg = s.req.data;
                      end
                      CMD_STEP: begin
                        next_s.steps = s.req.data;
                        next_s.st = (s.req.data == 8'h00) ? ST_STOP : ST_STEP;
                      end
                      default: next_s.st = ST_STOP;
                    endcase
                  end else begin
                    next_s.st = ST_STOP;
                  end
                end
              end
            end
          endcase
        end
      end
      ST_STOP: begin
        if (tick) begin
          next_s.q = s.q + 2'h1;
          case (s.q)
            // sda goes low under a low clock so that its later rise reads as a stop
            2'h0: next_s.sda_oe_n = 1'b0;
            2'h1: next_s.scl_oe_n = 1'b1;
            2'h2: next_s.scl_oe_n = 1'b1;
            default: begin
              next_s.sda_oe_n = 1'b1;
              if (s.polling && !s.poll_ok && s.timer != TW'(POLL_LIMIT)) begin
                next_s.st = ST_START;
              end else if (!s.polling && !s.rsp.nack && starts_nv_write(s.req.cmd)) begin
                // the stop launches the write cycle; poll until the device answers
                next_s.polling = 1'b1;
                next_s.timer = '0;
                next_s.st = ST_START;
              end else begin
                next_s.rsp.timeout = s.polling && !s.poll_ok;
                next_s.polling = 1'b0;
                next_s.done = 1'b1;
                next_s.ready = 1'b1;
                next_s.st = ST_IDLE;
              end
            end
          endcase
        end
      end
      default: next_s.st = ST_IDLE;
    endcase
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      // the bus starts released and the request port starts ready
      s <= '{
        st:        ST_IDLE,
        q:         2'h0,
        bitn:      4'h0,
        byte_idx:  2'h0,
        shreg:     8'h00,
        req:       '0,
        polling:   1'b0,
        poll_ok:   1'b0,
        steps:     8'h00,
        timer:     '0,
        rsp:       '0,
        done:      1'b0,
        ready:     1'b1,
        scl_oe_n:  1'b1,
        sda_oe_n:  1'b1,
        pin_level: 1'b0
      };
    end else begin
      s <= next_s;
    end
  end

  assign o_req_ready = s.ready;
  assign o_done      = s.done;
  assign o_rsp       = s.rsp;
  assign o_scl       = s.pin_level;
  assign o_scl_oe_n  = s.scl_oe_n;
  assign o_sda       = s.pin_level;
  assign o_sda_oe_n  = s.sda_oe_n;

endmodule

// file: pot_host_map.svh
// constants for the 2-wire host that drives a four-channel digital pot
// assumes a 100 MHz system clock; the host's parameter defaults convert times to cycles
`ifndef POT_HOST_MAP_SVH
`define POT_HOST_MAP_SVH

`define POT_CLK_NS          10
`define POT_BUS_BIT_NS      10000
`define POT_NV_WRITE_US     10000

// arbitrary neutral device type identifier, override per part
`define POT_TYPE_ID_DEFAULT 4'h3

`define POT_OP_READ_COUNTER  4'h9
`define POT_OP_WRITE_COUNTER 4'ha
`define POT_OP_READ_STORE    4'hb
`define POT_OP_WRITE_STORE   4'hc
`define POT_OP_STORE_TO_CNT  4'hd
`define POT_OP_CNT_TO_STORE  4'he
`define POT_OP_GLOBAL_TO_CNT 4'h1
`define POT_OP_GLOBAL_TO_ST  4'h8
`define POT_OP_STEP          4'h2

`define POT_ACK_SLOT         4'h8
`define POT_BYTE_ADDR        2'h0
`define POT_BYTE_INSTR       2'h1
`define POT_BYTE_DATA        2'h2

`endif

// file: pot_host_pkg.sv
// types shared by the pot bus host and its testbench
// assumes pot_host_map.svh supplies the numeric constants
package pot_host_pkg;

  typedef enum logic [3:0] {
    CMD_READ_COUNTER,
    CMD_WRITE_COUNTER,
    CMD_READ_STORE,
    CMD_WRITE_STORE,
    CMD_STORE_TO_COUNTER,
    CMD_COUNTER_TO_STORE,
    CMD_GLOBAL_TO_COUNTER,
    CMD_GLOBAL_TO_STORE,
    CMD_STEP
  } cmd_t;

  typedef struct packed {
    cmd_t       cmd;
    logic [3:0] chip_select_bits;
    logic [1:0] store_select;
    logic [1:0] channel_select;
    logic [7:0] data;
    logic       step_up;
  } req_t;

  typedef struct packed {
    logic [7:0] data;
    logic       nack;
    logic       timeout;
  } rsp_t;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_START,
    ST_SEND,
    ST_RECV,
    ST_STEP,
    ST_STOP
  } host_state_t;

endpackage

// file: link_tick_sync.sv
// quarter-bit tick divider and two-flop synchronisers for the bus pins
// assumes i_scl and i_sda are asynchronous wire levels from the pads
module link_tick_sync #(
  parameter int QUARTER_CYCLES = 250
) (
  input  wire logic i_clk,
  input  wire logic i_resetn,
  input  wire logic i_scl,
  input  wire logic i_sda,
  output logic      o_tick,
  output logic      o_scl,
  output logic      o_sda
);

  localparam int CW = $clog2(QUARTER_CYCLES + 1);

  typedef struct packed {
    logic [CW-1:0] count;
    logic          tick;
    logic [1:0]    scl_sync;
    logic [1:0]    sda_sync;
  } sync_state_t;

  sync_state_t s;
  sync_state_t next_s;

  always_comb begin
    next_s = s;
    next_s.tick = 1'b0;
    if (s.count == CW'(QUARTER_CYCLES - 1)) begin
      next_s.count = '0;
      next_s.tick = 1'b1;
    end else begin
      next_s.count = s.count + CW'(1);
    end
    // first stage feeds only the second stage
    next_s.scl_sync = {s.scl_sync[0], i_scl};
    next_s.sda_sync = {s.sda_sync[0], i_sda};
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      s <= '{count: '0, tick: 1'b0, scl_sync: 2'h3, sda_sync: 2'h3};
    end else begin
      s <= next_s;
    end
  end

  assign o_tick = s.tick;
  assign o_scl  = s.scl_sync[1];
  assign o_sda  = s.sda_sync[1];

endmodule

// file: pot_bus_host_checker.sv
// assertions on the pot bus host ports
// assumes it is bound into every pot_bus_host instance
module pot_bus_host_checker #(
  parameter int QUARTER_CYCLES = 250
) (
  input wire logic               i_clk,
  input wire logic               i_resetn,
  input wire logic               i_req_valid,
  input wire pot_host_pkg::req_t i_req,
  input wire logic               o_req_ready,
  input wire logic               o_done,
  input wire pot_host_pkg::rsp_t o_rsp,
  input wire logic               i_scl,
  input wire logic               o_scl,
  input wire logic               o_scl_oe_n,
  input wire logic               i_sda,
  input wire logic               o_sda,
  input wire logic               o_sda_oe_n
);
  timeunit 1ns;
  timeprecision 1ns;
  import pot_host_pkg::*;
  // the tick runs free, so the start waits up to two quarters after the accept
  localparam int START_MAX = 3 * QUARTER_CYCLES + 4;
  wire acc = i_req_valid && o_req_ready;
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_resetn);
  a_start_first: assert property (acc |-> o_scl_oe_n throughout (##[1:START_MAX] !o_sda_oe_n))
    else $error("start order wrong");
  a_idle_released: assert property (o_req_ready && !o_done |-> o_scl_oe_n && o_sda_oe_n)
    else $error("bus held while idle");
  a_open_drain: assert property (o_scl == 1'b0 && o_sda == 1'b0)
    else $error("pin value not low");
  a_accept_busy: assert property (acc |=> !o_req_ready)
    else $error("ready after accept");
  a_done_ready: assert property (o_done |-> o_req_ready)
    else $error("done without ready");
  a_done_pulse: assert property (o_done |=> !o_done)
    else $error("done longer than one cycle");
  a_rsp_hold: assert property ($changed(o_rsp) |-> !o_req_ready || o_done)
    else $error("response moved outside done");
  a_ready_back: assert property ($rose(o_req_ready) |-> o_done)
    else $error("ready returned without done");
endmodule

bind pot_bus_host pot_bus_host_checker #(.QUARTER_CYCLES(QUARTER_CYCLES)) chk_u (
  .i_clk, .i_resetn, .i_req_valid, .i_req, .o_req_ready, .o_done, .o_rsp,
  .i_scl, .o_scl, .o_scl_oe_n, .i_sda, .o_sda, .o_sda_oe_n);

// file: pot_dev_model.sv
// behavioural four-channel pot device on the 2-wire bus
// assumes pulled-up wire levels, sampled on the bench clock
module pot_dev_model #(
  parameter logic [3:0] TYPE_ID   = 4'ha, // arbitrary type id
  parameter logic [3:0] PINS      = 4'h6,
  parameter int         NV_CYCLES = 600
) (
  input  wire logic i_clk,
  input  wire logic i_resetn,
  input  wire logic i_scl,
  input  wire logic i_sda,
  output logic      o_sda_oe_n,
  output logic      o_master_acknowledge_bad,
  output logic      o_unused_bad
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] ctr [4];
  logic [7:0] st [16];
  logic [7:0] sh, ins, rd, dat;
  logic [3:0] n;
  logic [1:0] b, stepm;
  logic       pscl, psda, ok;
  int         busy;
  wire        rdm = ins[7:4] == 4'h9 || ins[7:4] == 4'hb;
  wire        match = sh == {TYPE_ID, PINS} && busy == 0;
  function automatic logic [7:0] sat(input logic [7:0] v, input logic up);
    if (up) return (v == 8'hff) ? v : v + 8'h1;
    return (v == 8'h00) ? v : v - 8'h1;
  endfunction
  // stores survive a power cycle, so only the first power-up fills them
  initial for (int i = 0; i < 16; i++) st[i] = 8'(8'h11 * i);
  always @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      for (int i = 0; i < 4; i++) ctr[i] <= st[i];
      {pscl, psda, o_sda_oe_n} <= 3'b111;
      {ok, o_master_acknowledge_bad, o_unused_bad} <= 3'b000;
      busy <= 0;
      stepm <= 2'd0;
    end else begin
      pscl <= i_scl;
      psda <= i_sda;
      if (busy > 0) busy <= busy - 1;
      if (pscl && i_scl && psda && !i_sda) begin
        {ok, n, b, stepm, o_sda_oe_n} <= {1'b1, 4'd0, 2'd0, 2'd0, 1'b1};
      end else if (pscl && i_scl && !psda && i_sda) begin
        {ok, stepm, o_sda_oe_n} <= {1'b0, 2'd0, 1'b1};
        if (ok && ins[7:4] inside {4'hc, 4'he, 4'h8} && b >= 2'd2) busy <= NV_CYCLES;
        if (ok) begin
          case (ins[7:4])
            4'ha: if (b == 2'd3) ctr[ins[1:0]] <= dat;
            4'hc: if (b == 2'd3) st[ins[3:0]] <= dat;
            4'hd: if (b == 2'd2) ctr[ins[1:0]] <= st[ins[3:0]];
            4'he: if (b == 2'd2) st[ins[3:0]] <= ctr[ins[1:0]];
            // a later poll frame keeps the old instruction, so only its own frame acts
            4'h1: if (b == 2'd2) for (int i = 0; i < 4; i++) ctr[i] <= st[{ins[3:2], 2'(i)}];
            4'h8: if (b == 2'd2) for (int i = 0; i < 4; i++) st[{ins[3:2], 2'(i)}] <= ctr[i];
            default: begin end
          endcase
        end
      end else if (ok && !pscl && i_scl && stepm == 2'd0) begin
        if (n != 4'd8) begin
          sh <= {sh[6:0], i_sda};
          n <= n + 4'd1;
        end else begin
          n <= 4'd0;
          b <= b + 2'd1;
          if (b == 2'd2) dat <= sh;
          if (b == 2'd1) begin
            ins <= sh;
            rd <= (sh[7:4] == 4'h9) ? ctr[sh[1:0]] : st[sh[3:0]];
            stepm <= {1'b0, sh[7:4] == 4'h2};
            if (sh[7:4] inside {4'h9, 4'ha, 4'h2} && sh[3:2] != 2'd0) o_unused_bad <= 1'b1;
            if (sh[7:4] inside {4'h1, 4'h8} && sh[1:0] != 2'd0) o_unused_bad <= 1'b1;
          end
          if (b == 2'd2 && rdm && i_sda) o_master_acknowledge_bad <= 1'b1;
        end
      end else if (ok && pscl && !i_scl) begin
        // counting on the falling edge keeps the stop's clock pulse out of the steps
        if (stepm == 2'd2) ctr[ins[1:0]] <= sat(ctr[ins[1:0]], psda);
        if (stepm == 2'd1) stepm <= 2'd2;
        if (n == 4'd8 && b == 2'd0) ok <= match;
        if (n == 4'd8) o_sda_oe_n <= (b == 2'd0) ? !match : (b == 2'd2 && rdm);
        else o_sda_oe_n <= (b == 2'd2 && rdm) ? rd[3'd7 - n[2:0]] : 1'b1;
      end
    end
  end
endmodule

// file: quad_pot_register_commands_tb.sv
// self-checking bench for the pot bus host against a device model
// assumes the host, its package, checker and device model compile first
module quad_pot_register_commands_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import pot_host_pkg::*;
  localparam logic [3:0] TID  = 4'ha; // arbitrary type id
  localparam logic [3:0] PINS = 4'h6;
  localparam logic [7:0] SV [4] = '{8'hfd, 8'hff, 8'h01, 8'h80};
  localparam int         SN [4] = '{5, 3, 4, 0};
  localparam logic [3:0] SU = 4'b1001;
  logic       i_clk = 1'b0;
  logic       i_resetn = 1'b0;
  logic       dev_resetn = 1'b0;
  logic       i_req_valid = 1'b0;
  req_t       i_req = '0;
  logic       o_req_ready, o_done, o_scl, o_scl_oe_n, o_sda, o_sda_oe_n;
  logic       dev_oe_n, master_acknowledge_bad, unused_bad;
  rsp_t       o_rsp;
  logic [7:0] ctr [4];
  logic [7:0] st [16];
  int         errors = 0;
  int         total_checks = 0;
  int         cycles = 0;
  wire        scl = o_scl_oe_n ? 1'b1 : o_scl;
  wire        sda = (o_sda_oe_n ? 1'b1 : o_sda) & dev_oe_n;
  initial forever #5 i_clk = ~i_clk;
  pot_bus_host #(.QUARTER_CYCLES(4), .POLL_LIMIT(2000), .TYPE_ID(TID)) dut_u (
    .i_clk, .i_resetn, .i_req_valid, .i_req, .o_req_ready, .o_done, .o_rsp,
    .i_scl(scl), .o_scl, .o_scl_oe_n, .i_sda(sda), .o_sda, .o_sda_oe_n);
  pot_dev_model #(.TYPE_ID(TID), .PINS(PINS), .NV_CYCLES(600)) dev_u (
    .i_clk, .i_resetn(dev_resetn), .i_scl(scl), .i_sda(sda), .o_sda_oe_n(dev_oe_n),
    .o_master_acknowledge_bad(master_acknowledge_bad), .o_unused_bad(unused_bad));
  function automatic logic [7:0] steps(input logic [7:0] v, input int cnt, input logic up);
    for (int k = 0; k < cnt; k++) begin
      if (up) v = (v == 8'hff) ? v : v + 8'h1;
      else v = (v == 8'h00) ? v : v - 8'h1;
    end
    return v;
  endfunction
  task automatic stop_test();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %0t seen %h want %h", $time, seen, exp);
    end
  endtask
  task automatic run(input cmd_t c, input logic [1:0] s, input logic [1:0] ch,
                     input logic [7:0] d, input logic up, input logic [3:0] cs);
    int k;
    @(negedge i_clk);
    i_req <= '{c, cs, s, ch, d, up};
    i_req_valid <= 1'b1;
    @(negedge i_clk);
    i_req_valid <= 1'b0;
    k = 0;
    while (o_done !== 1'b1 && k < 20000) begin
      @(negedge i_clk);
      k++;
    end
    if (k == 20000) begin
      errors++;
      $display("BAD %0t no done from host", $time);
    end
  endtask
  // counter reads send random store bits, which the host must clear
  task automatic rd_chk(input logic store, input logic [3:0] a);
    run(store ? CMD_READ_STORE : CMD_READ_COUNTER, store ? a[3:2] : 2'($urandom), a[1:0],
        8'($urandom), 1'b0, PINS);
    chk(o_rsp.data, store ? st[a] : ctr[a[1:0]]);
  endtask
  always @(posedge i_clk) begin
    cycles <= cycles + 1;
    if (cycles == 80000) begin
      $display("BAD %0t run too long", $time);
      errors++;
      stop_test();
    end
  end
  initial begin
    logic [7:0] v;
    logic [3:0] a;
    void'($urandom(32'ha702));
    for (int i = 0; i < 16; i++) st[i] = 8'(8'h11 * i);
    for (int i = 0; i < 4; i++) ctr[i] = st[i];
    repeat (10) @(negedge i_clk);
    i_resetn = 1'b1;
    dev_resetn = 1'b1;
    chk({6'h0, o_req_ready, o_scl_oe_n & o_sda_oe_n}, 8'h03);
    for (int i = 0; i < 4; i++) begin
      ctr[i] = $urandom;
      run(CMD_WRITE_COUNTER, 2'($urandom), 2'(i), ctr[i], 1'b0, PINS);
    end
    for (int i = 0; i < 4; i++) rd_chk(1'b0, 4'(i));
    repeat (3) begin
      a = $urandom;
      st[a] = $urandom;
      run(CMD_WRITE_STORE, a[3:2], a[1:0], st[a], 1'b0, PINS);
      chk({6'h0, o_rsp.nack, o_rsp.timeout}, 8'h00);
      rd_chk(1'b1, a);
    end
    run(CMD_STORE_TO_COUNTER, 2'd2, 2'd1, 8'h00, 1'b0, PINS);
    ctr[1] = st[4'h9];
    rd_chk(1'b0, 4'h1);
    run(CMD_COUNTER_TO_STORE, 2'd0, 2'd2, 8'h00, 1'b0, PINS);
    st[4'h2] = ctr[2];
    rd_chk(1'b1, 4'h2);
    for (int i = 0; i < 4; i++) begin
      run(CMD_WRITE_COUNTER, 2'd0, 2'(i), SV[i], 1'b0, PINS);
      run(CMD_STEP, 2'($urandom), 2'(i), 8'(SN[i]), SU[i], PINS);
      ctr[i] = steps(SV[i], SN[i], SU[i]);
      rd_chk(1'b0, 4'(i));
    end
    run(CMD_GLOBAL_TO_COUNTER, 2'd1, 2'($urandom), 8'h00, 1'b0, PINS);
    for (int i = 0; i < 4; i++) ctr[i] = st[{2'd1, 2'(i)}];
    for (int i = 0; i < 4; i++) rd_chk(1'b0, 4'(i));
    run(CMD_GLOBAL_TO_STORE, 2'd3, 2'($urandom), 8'h00, 1'b0, PINS);
    for (int i = 0; i < 4; i++) st[{2'd3, 2'(i)}] = ctr[i];
    for (int i = 0; i < 4; i++) rd_chk(1'b1, {2'd3, 2'(i)});
    // a device reset clears its flags, so look at them before every reset
    chk({6'h0, master_acknowledge_bad, unused_bad}, 8'h00);
    // keep the device in reset across the polling, so the host must give up
    a = $urandom;
    st[a] = $urandom;
    fork
      run(CMD_WRITE_STORE, a[3:2], a[1:0], st[a], 1'b0, PINS);
      begin
        repeat (600) @(negedge i_clk);
        dev_resetn = 1'b0;
      end
    join
    dev_resetn = 1'b1;
    for (int i = 0; i < 4; i++) ctr[i] = st[i];
    chk({6'h0, o_rsp.nack, o_rsp.timeout}, 8'h01);
    rd_chk(1'b1, a);
    v = ~st[2];
    run(CMD_WRITE_COUNTER, 2'd0, 2'd2, v, 1'b0, PINS);
    chk({6'h0, master_acknowledge_bad, unused_bad}, 8'h00);
    dev_resetn = 1'b0;
    repeat (2) @(negedge i_clk);
    dev_resetn = 1'b1;
    for (int i = 0; i < 4; i++) ctr[i] = st[i];
    rd_chk(1'b0, 4'h2);
    run(CMD_READ_COUNTER, 2'd0, 2'd0, 8'h00, 1'b0, PINS ^ 4'(1 + $urandom % 15));
    chk({7'h0, o_rsp.nack}, 8'h01);
    chk({6'h0, master_acknowledge_bad, unused_bad}, 8'h00);
    stop_test();
  end
endmodule
